// file: src/piu_top.sv
// Purpose: execution of supervisor-only instructions, breakpoint, timer, pending map
// Assumes: one instruction in flight; mode supplied with each instruction
// Notes:   APB slave has no wait states; unmapped offsets answer pslverr
`include "piu_regs.svh"

// Notes on behaviour
// RQ1 - idle enables interrupts, halts until one
// RQ2 - breakpoint code copies R to breakpoint
// RQ3 - address match sets data flag bit 47
// RQ4 - usage bits pick write and read operands
// RQ5 - test mode only in supervisor, else no-op
// RQ6 - designator one sets, zero clears mode
// RQ7 - bit 8 disables single-error correction
// RQ8 - bits 9-15 invert write checkword bits
// RQ9 - software clears test modes before exchange
// RQ10 - io raises selected channel flag, continues
// RQ11 - user exit goes to supervisor vector
// RQ12 - supervisor exit uses T package, S origin
// RQ13 - zero S keeps shared register file
// RQ14 - high sixteen bits of S, T ignored
// RQ15 - timer load takes low 32 bits
// RQ16 - translation registers move at 4000 hex
// RQ17 - contents after store are undefined
// RQ18 - pending bit n is channel n
// RQ19 - unused designators are zero by software
// RQ20 - translate reports lowest pending as code
// RQ21 - translate clears only the reported bit
// RQ22 - privileged codes trap in user mode
module piu_top (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic           [11:0] paddr,
  input  wire logic           [31:0] pwdata,
  output logic                [31:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire piu_pkg::piu_ins_t     ins,
  output logic                       ins_ready,
  input  wire piu_pkg::piu_opnd_t    opnd,
  input  wire logic           [16:0] chan_irq,
  input  wire logic                  mem_ack,
  input  wire logic           [63:0] mem_rdata,
  output piu_pkg::piu_mem_req_t      mem_req,
  output piu_pkg::piu_res_t          res,
  output piu_pkg::piu_xchg_t         xchg,
  output piu_pkg::piu_br_t           br,
  output logic                       trap,
  output logic                       halted,
  output logic                       ext_irq_en,
  output logic                       secded_dis,
  output logic                [6:0]  chk_inv,
  output logic                [16:0] chan_flag,
  output logic                       df_bp_set
);
  import piu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  piu_state_t                    state_ff, nxt_state;
  logic [63:0]                   bp_ff;
  logic [31:0]                   tmr_ff;
  logic [`PIU_PEND_W-1:0]        pend_ff;
  logic [47:0]                   exv_ff;
  logic [3:0]                    xr_idx_ff;
  logic [63:0]                   xr_ff [`PIU_XR_NUM];
  logic                          irq_en_ff;
  logic                          dis_ff;
  logic [6:0]                    inv_ff;
  logic [16:0]                   flag_ff;
  logic                          bp_hit_ff;
  logic                          trap_ff;
  piu_res_t                      res_ff;
  piu_xchg_t                     xchg_ff;
  piu_br_t                       br_ff;

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode
  wire take      = ins.valid & ins_ready;
  wire fn_idle   = ins.func == `PIU_FN_IDLE;
  wire fn_brk    = ins.func == `PIU_FN_BRK;
  wire fn_test   = ins.func == `PIU_FN_TEST;
  wire fn_io     = ins.func == `PIU_FN_IO;
  wire fn_exit   = ins.func == `PIU_FN_EXIT;
  wire fn_tmr    = ins.func == `PIU_FN_TIMER;
  wire fn_sto    = ins.func == `PIU_FN_XR_STORE;
  wire fn_lod    = ins.func == `PIU_FN_XR_LOAD;
  wire fn_xl     = ins.func == `PIU_FN_XLATE;
  wire fn_priv   = fn_idle | fn_io | fn_tmr | fn_sto | fn_lod | fn_xl;
  wire fn_known  = fn_priv | fn_brk | fn_test | fn_exit;
  wire sup_go    = take & ins.sup;
  // test mode in user mode is a plain no-op, so it is not in fn_priv
  wire do_trap   = take & ((fn_priv & ~ins.sup) | ~fn_known); // RQ22
  wire do_idle   = sup_go & fn_idle;
  wire do_brk    = take & fn_brk;
  wire do_test   = sup_go & fn_test;                          // RQ5
  wire do_io     = sup_go & fn_io;
  wire do_tmr    = sup_go & fn_tmr;
  wire do_sto    = sup_go & fn_sto;
  wire do_lod    = sup_go & fn_lod;
  wire do_xl     = sup_go & fn_xl;
  wire exit_user = take & fn_exit & ~ins.sup;
  wire exit_sup  = take & fn_exit & ins.sup;

  ////////////////////////////////////////////////////////////////////////////
  // pending register: lowest set bit, single-bit test
  logic [4:0]             low_code;
  logic [`PIU_PEND_W-1:0] low_hot;
  always_comb begin
    low_code = 5'h00;
    low_hot  = '0;
    for (int i = `PIU_PEND_W - 1; i >= 1; i--) begin
      if (pend_ff[i]) begin
        low_code = 5'(i); // RQ20
        low_hot  = `PIU_PEND_W'(1) << i;
      end
    end
  end

  wire pend_any = |pend_ff;
  wire pend_one = pend_any & ~|(pend_ff & (pend_ff - `PIU_PEND_W'(1)));

  // bit 0 never sets; channels land on their own index
  wire tmr_exp = (tmr_ff == 32'h0000_0001) & ~do_tmr;
  wire [`PIU_PEND_W-1:0] pend_set = {tmr_exp, chan_irq[16:1], 1'b0};     // RQ18

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  wire        apb_acc = psel & penable;
  wire        apb_wr  = apb_acc & pwrite;
  wire        sel_st  = paddr == `PIU_OFF_STATUS;
  wire        sel_bpl = paddr == `PIU_OFF_BP_LO;
  wire        sel_bph = paddr == `PIU_OFF_BP_HI;
  wire        sel_tmr = paddr == `PIU_OFF_TIMER;
  wire        sel_pnd = paddr == `PIU_OFF_PEND;
  wire        sel_exl = paddr == `PIU_OFF_EXV_LO;
  wire        sel_exh = paddr == `PIU_OFF_EXV_HI;
  wire        mapped  = sel_st | sel_bpl | sel_bph | sel_tmr | sel_pnd | sel_exl | sel_exh;
  wire [31:0] status  = {21'h00_0000, inv_ff, dis_ff, irq_en_ff,
                         state_ff == ST_IDLE, state_ff != ST_RUN};

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~mapped;
  assign prdata  = sel_st  ? status :
                   sel_bpl ? bp_ff[31:0] :
                   sel_bph ? bp_ff[63:32] :
                   sel_tmr ? tmr_ff :
                   sel_pnd ? {14'h0000, pend_ff} :
                   sel_exl ? exv_ff[31:0] :
                   sel_exh ? {16'h0000, exv_ff[47:32]} : 32'h0000_0000;

  // set wins over both clears
  wire [`PIU_PEND_W-1:0] pend_clr = (do_xl ? low_hot : '0) |                  // RQ21
                                    (apb_wr & sel_pnd ? pwdata[`PIU_PEND_W-1:0] : '0);
  wire [`PIU_PEND_W-1:0] nxt_pend = (pend_ff & ~pend_clr) | pend_set;

  ////////////////////////////////////////////////////////////////////////////
  // breakpoint
  logic bp_hit;
  piu_bp_cmp u_bp_cmp (
    .bp_word (bp_ff),
    .opnd    (opnd),
    .hit     (bp_hit)
  );

  wire [63:0] nxt_bp = do_brk         ? ins.r_val : // RQ2
                       apb_wr & sel_bpl ? {bp_ff[63:32], pwdata} :
                       apb_wr & sel_bph ? {pwdata, bp_ff[31:0]} : bp_ff;

  wire [47:0] nxt_exv = apb_wr & sel_exl ? {exv_ff[47:32], pwdata} :
                        apb_wr & sel_exh ? {pwdata[15:0], exv_ff[31:0]} : exv_ff;

  ////////////////////////////////////////////////////////////////////////////
  // timer, test modes, channel flags
  wire [31:0] nxt_tmr = do_tmr ? ins.r_val[31:0] : // RQ15
                        (tmr_ff != 32'h0000_0000) ? tmr_ff - 32'h0000_0001 : tmr_ff;

  wire        nxt_dis = do_test ? ins.r_des[`PIU_TEST_DIS_BIT] : dis_ff;       // RQ6 RQ7
  wire [6:0]  nxt_inv = do_test ? ins.r_des[`PIU_TEST_INV_MSB:0] : inv_ff;     // RQ6 RQ8

  // out-of-range channel numbers raise nothing
  wire        io_ok    = (ins.r_des != 8'h00) & (ins.r_des <= 8'(`PIU_CHAN_LAST));
  wire [16:0] nxt_flag = (do_io & io_ok) ? 17'h00001 << ins.r_des[4:0] : 17'h00000; // RQ10

  wire nxt_irq_en = (do_idle | exit_sup) ? 1'b1 :                              // RQ1
                    (exit_user | do_trap) ? 1'b0 : irq_en_ff;

  ////////////////////////////////////////////////////////////////////////////
  // exchange, translate result and branch
  wire [47:0] s_addr = ins.s_val[47:0]; // RQ14
  wire [47:0] t_addr = ins.t_val[47:0]; // RQ14
  piu_xchg_t nxt_xchg;
  assign nxt_xchg.valid     = exit_user | exit_sup;
  assign nxt_xchg.to_sup    = exit_user; // RQ11
  assign nxt_xchg.same_rf   = exit_sup & ((ins.s_des == 8'h00) | (s_addr == 48'h0)); // RQ13
  assign nxt_xchg.target    = exit_user ? exv_ff : t_addr;                     // RQ11 RQ12
  assign nxt_xchg.rf_origin = exit_sup ? s_addr : `PIU_RST_A48;                // RQ12
  assign nxt_xchg.bp_save   = bp_ff; // RQ2

  piu_res_t nxt_res;
  assign nxt_res.valid = do_xl;
  assign nxt_res.t_des = ins.t_des;
  assign nxt_res.data  = {59'h0, low_code}; // RQ20

  // branch index counts half-words of 32 bits
  piu_br_t nxt_br;
  assign nxt_br.valid  = do_xl & pend_one;
  assign nxt_br.target = ins.r_val[47:0] + {ins.s_val[42:0], 5'h00};

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: idle wait and translation register transfers
  wire xr_last = xr_idx_ff == `PIU_XR_LAST;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (do_idle) begin
          nxt_state = ST_IDLE; // RQ1
        end else if (do_sto) begin
          nxt_state = ST_STORE; // RQ16
        end else if (do_lod) begin
          nxt_state = ST_LOAD; // RQ16
        end
      end
      ST_IDLE: begin
        if (pend_any) begin
          nxt_state = ST_RUN; // RQ1
        end
      end
      ST_STORE, ST_LOAD: begin
        if (mem_ack & xr_last) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  wire        xr_step    = (state_ff == ST_STORE || state_ff == ST_LOAD) & mem_ack;
  // index holds through memory wait cycles, wraps to zero after the last word
  wire [3:0]  nxt_xr_idx = xr_step ? xr_idx_ff + 4'h1 :
                           mem_req.valid ? xr_idx_ff : 4'h0;
  wire        xr_wr      = (state_ff == ST_LOAD) & mem_ack;

  // entries stay as they were after a store; software must not count on that
  generate
    for (genvar g = 0; g < `PIU_XR_NUM; g++) begin : g_xr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          xr_ff[g] <= `PIU_RST_W64;
        end else if (xr_wr && xr_idx_ff == 4'(g)) begin
          xr_ff[g] <= mem_rdata; // RQ16 RQ17
        end
      end
    end
  endgenerate

  assign mem_req.valid = (state_ff == ST_STORE) | (state_ff == ST_LOAD);
  assign mem_req.write = state_ff == ST_STORE;
  assign mem_req.addr  = `PIU_XR_BASE + {44'h0, xr_idx_ff};                    // RQ16
  assign mem_req.wdata = xr_ff[xr_idx_ff];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= ST_RUN;
      bp_ff     <= `PIU_RST_W64;
      tmr_ff    <= `PIU_RST_W32;
      pend_ff   <= '0;
      exv_ff    <= `PIU_RST_A48;
      xr_idx_ff <= 4'h0;
      irq_en_ff <= 1'b0;
      dis_ff    <= 1'b0;
      inv_ff    <= 7'h00;
      flag_ff   <= 17'h00000;
      bp_hit_ff <= 1'b0;
      trap_ff   <= 1'b0;
      res_ff    <= '0;
      xchg_ff   <= '0;
      br_ff     <= '0;
    end else begin
      state_ff  <= nxt_state;
      bp_ff     <= nxt_bp;
      tmr_ff    <= nxt_tmr;
      pend_ff   <= nxt_pend;
      exv_ff    <= nxt_exv;
      xr_idx_ff <= nxt_xr_idx;
      irq_en_ff <= nxt_irq_en;
      dis_ff    <= nxt_dis;
      inv_ff    <= nxt_inv;
      flag_ff   <= nxt_flag;
      bp_hit_ff <= bp_hit; // RQ3
      trap_ff   <= do_trap; // RQ22
      res_ff    <= nxt_res;
      xchg_ff   <= nxt_xchg;
      br_ff     <= nxt_br;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ins_ready  = state_ff == ST_RUN;
  assign halted     = state_ff == ST_IDLE;
  assign ext_irq_en = irq_en_ff;
  assign secded_dis = dis_ff;
  assign chk_inv    = inv_ff;
  assign chan_flag  = flag_ff;
  assign df_bp_set  = bp_hit_ff;
  assign trap       = trap_ff;
  assign res        = res_ff;
  assign xchg       = xchg_ff;
  assign br         = br_ff;
endmodule

// file: src/piu_regs.svh
// Purpose: constants of the privileged instruction unit
// Assumes: included by bare name from the design files
// Notes:   offsets are APB byte addresses; bit positions are little-endian indices
`ifndef PIU_REGS_SVH
`define PIU_REGS_SVH

// function codes
`define PIU_FN_IDLE     8'h00
`define PIU_FN_BRK      8'h04
`define PIU_FN_TEST     8'h06
`define PIU_FN_IO       8'h08
`define PIU_FN_EXIT     8'h09
`define PIU_FN_TIMER    8'h0A
`define PIU_FN_XR_STORE 8'h0C
`define PIU_FN_XR_LOAD  8'h0D
`define PIU_FN_XLATE    8'h0E

// APB register offsets
`define PIU_OFF_STATUS  12'h000
`define PIU_OFF_BP_LO   12'h004
`define PIU_OFF_BP_HI   12'h008
`define PIU_OFF_TIMER   12'h00C
`define PIU_OFF_PEND    12'h010
`define PIU_OFF_EXV_LO  12'h014
`define PIU_OFF_EXV_HI  12'h018

// test-mode designator fields (designator bit 7 is the disable bit, bit 6 the inversion field's msb)
`define PIU_TEST_DIS_BIT 7
`define PIU_TEST_INV_MSB 6

// breakpoint word fields
`define PIU_BP_ADDR_MSB 47
`define PIU_BP_ADDR_LSB 5
`define PIU_BP_WR_BIT   2
`define PIU_BP_RD_BIT   1

// pending register layout
`define PIU_PEND_W      18
`define PIU_PEND_TIMER  17
`define PIU_CHAN_LAST   16

// translation register block
`define PIU_XR_NUM      16
`define PIU_XR_LAST     4'hF
`define PIU_XR_BASE     48'h0000_0000_4000

// reset values
`define PIU_RST_W64     64'h0000_0000_0000_0000
`define PIU_RST_A48     48'h0000_0000_0000
`define PIU_RST_W32     32'h0000_0000

`endif

// file: src/piu_pkg.sv
// Purpose: types shared by the privileged instruction unit
// Assumes: one processor clock
// Notes:   field widths follow the 64-bit word and 48-bit address
package piu_pkg;

  typedef struct packed {
    logic        valid;
    logic        sup;
    logic [7:0]  func;
    logic [7:0]  r_des;
    logic [7:0]  s_des;
    logic [7:0]  t_des;
    logic [63:0] r_val;
    logic [63:0] s_val;
    logic [63:0] t_val;
  } piu_ins_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [47:0] addr;
  } piu_opnd_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  t_des;
    logic [63:0] data;
  } piu_res_t;

  typedef struct packed {
    logic        valid;
    logic        to_sup;
    logic        same_rf;
    logic [47:0] target;
    logic [47:0] rf_origin;
    logic [63:0] bp_save;
  } piu_xchg_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [47:0] addr;
    logic [63:0] wdata;
  } piu_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] target;
  } piu_br_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_STORE,
    ST_LOAD
  } piu_state_t;

endpackage

// file: src/piu_bp_cmp.sv
// Purpose: breakpoint address compare on processor operands
// Assumes: one operand request per cycle at most
// Notes:   combinational; the caller registers the hit
`include "piu_regs.svh"
module piu_bp_cmp (
  input  wire logic               [63:0] bp_word,
  input  wire piu_pkg::piu_opnd_t        opnd,
  output logic                           hit
);
  import piu_pkg::*;

  wire addr_eq = opnd.addr[`PIU_BP_ADDR_MSB:`PIU_BP_ADDR_LSB] ==
                 bp_word[`PIU_BP_ADDR_MSB:`PIU_BP_ADDR_LSB]; // RQ3
  wire wr_sel  = opnd.write & bp_word[`PIU_BP_WR_BIT];          // RQ4
  wire rd_sel  = ~opnd.write & bp_word[`PIU_BP_RD_BIT];         // RQ4

  assign hit = opnd.valid & addr_eq & (wr_sel | rd_sel);        // RQ3
endmodule

// file: verification/piu_monitor.sv
// Purpose: port-level assertions for the privileged instruction unit
// Assumes: one clock, presetn asynchronous and active low
// Notes:   breakpoint word shadowed from instructions only; bench loads it that way
module piu_monitor (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire piu_pkg::piu_ins_t     ins,
  input wire logic                  ins_ready,
  input wire piu_pkg::piu_opnd_t    opnd,
  input wire piu_pkg::piu_mem_req_t mem_req,
  input wire piu_pkg::piu_res_t     res,
  input wire piu_pkg::piu_xchg_t    xchg,
  input wire logic                  trap,
  input wire logic                  halted,
  input wire logic                  ext_irq_en,
  input wire logic                  secded_dis,
  input wire logic           [6:0]  chk_inv,
  input wire logic           [16:0] chan_flag,
  input wire logic                  df_bp_set
);
  timeunit 1ns;
  timeprecision 1ps;
  import piu_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic [63:0] bp_ff;
  wire         take  = ins.valid && ins_ready;
  wire         s_tk  = take && ins.sup;
  wire         u_tk  = take && !ins.sup;
  wire         r_msb = ins.r_des[7];
  wire [6:0]   r_low = ins.r_des[6:0];
  wire [47:0]  t_lo  = ins.t_val[47:0];
  wire [47:0]  s_lo  = ins.s_val[47:0];
  wire         same  = (ins.s_des == 8'h00) || (s_lo == 48'h0);
  wire         priv  = ins.func inside {8'h00, 8'h08, 8'h0A, 8'h0C, 8'h0D, 8'h0E};
  wire         hit   = opnd.valid && (opnd.addr[47:5] == bp_ff[47:5])
                       && (opnd.write ? bp_ff[2] : bp_ff[1]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_ff <= 64'h0;
    end else if (take && ins.func == 8'h04) begin
      bp_ff <= ins.r_val;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_bp_hit_set: assert property (hit |=> df_bp_set)
    else $error("operand match without data flag");
  a_bp_miss_quiet: assert property (!hit |=> !df_bp_set)
    else $error("data flag without qualifying match");
  a_idle_halts: assert property (s_tk && ins.func == 8'h00 |=> halted && ext_irq_en && !ins_ready)
    else $error("idle did not halt with interrupts enabled");
  a_test_sets: assert property (s_tk && ins.func == 8'h06 |=>
    secded_dis == $past(r_msb) && chk_inv == $past(r_low))
    else $error("test mode bits not taken from designator");
  a_test_user_nop: assert property (u_tk && ins.func == 8'h06 |=>
    $stable(secded_dis) && $stable(chk_inv) && !trap)
    else $error("user test mode was not a no-op");
  a_io_flag: assert property (s_tk && ins.func == 8'h08 && ins.r_des inside {[8'h01:8'h10]}
    |=> chan_flag == (17'h00001 << $past(ins.r_des)))
    else $error("wrong channel flag raised");
  a_user_trap: assert property (u_tk && priv |=> trap && !xchg.valid && chan_flag == 17'h00000)
    else $error("privileged code in user mode did not trap");
  a_exit_job: assert property (s_tk && ins.func == 8'h09 |=> xchg.valid && !xchg.to_sup
    && xchg.target == $past(t_lo) && xchg.rf_origin == $past(s_lo) && xchg.same_rf == $past(same))
    else $error("supervisor exit exchange fields wrong");
  a_exit_sup: assert property (u_tk && ins.func == 8'h09 |=> xchg.valid && xchg.to_sup)
    else $error("user exit did not exchange to supervisor");
  a_xlate_code: assert property (s_tk && ins.func == 8'h0E |=> res.valid && res.data[63:5] == 59'h0)
    else $error("translate result not a five-bit code");
  a_mem_window: assert property (mem_req.valid |-> mem_req.addr[47:4] == 44'h000_0000_0400)
    else $error("translation transfer outside its block");
  c_bp_hit: cover property (df_bp_set);
  c_idle_wake: cover property (halted ##1 !halted);
  c_xr_store: cover property (mem_req.valid && mem_req.write);
endmodule

bind piu_top piu_monitor mon_u (.pclk, .presetn, .ins, .ins_ready, .opnd, .mem_req, .res, .xchg,
  .trap, .halted, .ext_irq_en, .secded_dis, .chk_inv, .chan_flag, .df_bp_set);

// file: verification/piu_mem_model.sv
// Purpose: central memory stand-in for translation register transfers
// Assumes: request held until acknowledged
// Notes:   slow mode inserts three wait cycles; idle read data toggles
module piu_mem_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  slow,
  input  wire piu_pkg::piu_mem_req_t mem_req,
  output logic                       mem_ack,
  output logic              [63:0]   mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import piu_pkg::*;
  logic [63:0] mem [16];
  logic [1:0]  wait_ff;
  wire  [3:0]  idx = mem_req.addr[3:0];
  wire         go  = mem_req.valid && !mem_ack && (wait_ff == (slow ? 2'h3 : 2'h0));
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 64'hC3A5_0F1E_9B00_0000 | i;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff   <= 2'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 64'h0;
    end else if (go) begin
      mem_ack   <= 1'b1;
      wait_ff   <= 2'h0;
      mem_rdata <= mem[idx];
      if (mem_req.write) mem[idx] <= mem_req.wdata;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

// file: verification/piu_top_bench.sv
// Purpose: self-checking bench for the privileged instruction unit
// Assumes: drives at rising edges; bus data taken at the pready edge
// Notes:   waits on pready and ins_ready under bounded loops
module piu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import piu_pkg::*;
  localparam logic [63:0] zw = 64'h0;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         slow = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic [16:0]  chan_irq = 17'h00000, chan_flag;
  piu_ins_t     ins = '0;
  piu_opnd_t    opnd = '0;
  logic         pready, pslverr, ins_ready, mem_ack, trap, halted, ext_irq_en, secded_dis;
  logic         df_bp_set, err;
  logic [63:0]  mem_rdata;
  logic [6:0]   chk_inv;
  piu_mem_req_t mem_req;
  piu_res_t     res;
  piu_xchg_t    xchg;
  piu_br_t      br;
  int           n_fail = 0;
  int           comparisons = 0;
  always #12.5 pclk = ~pclk;
  piu_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ins, .ins_ready, .opnd, .chan_irq, .mem_ack, .mem_rdata, .mem_req, .res, .xchg,
    .br, .trap, .halted, .ext_irq_en, .secded_dis, .chk_inv, .chan_flag, .df_bp_set);
  piu_mem_model mem_u (.pclk, .presetn, .slow, .mem_req, .mem_ack, .mem_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic give_up;
    n_fail++;
    $display("MISMATCH wait expected done seen timeout");
    give_verdict();
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) give_up();
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(nm, {31'h0, ee, e}, {31'h0, err, rd});
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 200 && ins_ready !== 1'b1; k++) @(negedge pclk);
    if (k == 200) give_up();
  endtask
  task automatic exec(input logic s, input logic [7:0] f, r, sd, input logic [63:0] rv, sv, tv);
    @(posedge pclk);
    ins <= '{1'b1, s, f, r, sd, (f == 8'h0E) ? 8'h07 : 8'h00, rv, sv, tv};
    @(negedge pclk);
    wait_ready();
    @(posedge pclk);
    ins.valid <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic probe(input logic w, input logic [47:0] a, input logic e);
    @(posedge pclk);
    opnd <= '{1'b1, w, a};
    @(posedge pclk);
    opnd.valid <= 1'b0;
    @(negedge pclk);
    chk("bp flag", {63'h0, e}, {63'h0, df_bp_set});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] tm [3] = '{8'h80, 8'h55, 8'h00};
    logic [7:0] pv [6] = '{8'h00, 8'h08, 8'h0A, 8'h0C, 8'h0D, 8'h0E};
    int i;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status", 12'h000, 32'h0, 1'b0);
    rdchk("unmapped", 12'h01C, 32'h0, 1'b1);
    $display("reset and map done");
    exec(1'b0, 8'h04, 8'h00, 8'h00, 64'hFFFF_1234_5678_9AA4, zw, zw);
    rdchk("bp lo", 12'h004, 32'h5678_9AA4, 1'b0);
    rdchk("bp hi", 12'h008, 32'hFFFF_1234, 1'b0);
    probe(1'b1, 48'h1234_5678_9ABF, 1'b1);
    probe(1'b0, 48'h1234_5678_9ABF, 1'b0);
    probe(1'b1, 48'h1234_5678_9AC4, 1'b0);
    exec(1'b1, 8'h04, 8'h00, 8'h00, 64'h0000_1234_5678_9AA2, zw, zw);
    probe(1'b0, 48'h1234_5678_9AA0, 1'b1);
    probe(1'b1, 48'h1234_5678_9AA0, 1'b0);
    $display("breakpoint done");
    for (i = 0; i < 3; i++) begin
      exec(1'b1, 8'h06, tm[i], 8'h00, zw, zw, zw);
      chk("test modes", {56'h0, tm[i]}, {56'h0, secded_dis, chk_inv});
    end
    exec(1'b0, 8'h06, 8'hFF, 8'h00, zw, zw, zw);
    chk("user test", zw, {55'h0, trap, secded_dis, chk_inv});
    $display("test mode done");
    for (i = 1; i <= 16; i++) begin
      exec(1'b1, 8'h08, i[7:0], 8'h00, zw, zw, zw);
      chk("chan flag", 64'h1 << i, {47'h0, chan_flag});
    end
    for (i = 0; i < 6; i++) begin
      exec(1'b0, pv[i], 8'h00, 8'h00, zw, zw, zw);
      chk("user trap", 64'h1, {46'h0, chan_flag, trap});
    end
    $display("io and trap done");
    exec(1'b1, 8'h0A, 8'h00, 8'h00, 64'hFFFF_FFFF_0000_0008, zw, zw);
    rd = 32'h0;
    for (i = 0; i < 20 && rd[17] !== 1'b1; i++) apb(1'b0, 12'h010, 32'h0);
    if (i == 20) give_up();
    chk("timer pend", 64'h2_0000, {32'h0, rd});
    rdchk("timer", 12'h00C, 32'h0, 1'b0);
    apb(1'b1, 12'h010, 32'h0002_0000);
    $display("timer done");
    @(posedge pclk);
    chan_irq <= 17'h00209;
    @(posedge pclk);
    chan_irq <= 17'h00000;
    rdchk("pend", 12'h010, 32'h0000_0208, 1'b0);
    exec(1'b1, 8'h0E, 8'h00, 8'h05, 64'h1000, 64'h4, zw);
    chk("code", 64'h0700_0000_0000_0003, {res.t_des, res.data[55:0]});
    chk("no branch", zw, {63'h0, br.valid});
    rdchk("pend", 12'h010, 32'h0000_0200, 1'b0);
    exec(1'b1, 8'h0E, 8'h00, 8'h05, 64'h1000, 64'h4, zw);
    chk("code", 64'h9, res.data);
    chk("branch", 64'h0001_0000_0000_1080, {15'h0, br.valid, br.target});
    rdchk("pend", 12'h010, 32'h0, 1'b0);
    $display("translate done");
    apb(1'b1, 12'h014, 32'h0000_2000);
    apb(1'b1, 12'h018, 32'h0000_0ABC);
    exec(1'b0, 8'h09, 8'h00, 8'h00, zw, zw, zw);
    chk("to sup", 64'h0001_0ABC_0000_2000, {15'h0, xchg.to_sup, xchg.target});
    exec(1'b1, 8'h09, 8'h00, 8'h05, zw, 64'hFFFF_0000_0010_0000, 64'hA5A5_0000_0040_0000);
    chk("job target", 64'h0000_0000_0040_0000, {15'h0, xchg.to_sup, xchg.target});
    chk("job origin", 64'h0000_0000_0010_0000, {15'h0, xchg.same_rf, xchg.rf_origin});
    exec(1'b1, 8'h09, 8'h00, 8'h00, zw, 64'h0010_0000, 64'h0040_0000);
    chk("shared rf", 64'h1, {63'h0, xchg.same_rf});
    exec(1'b1, 8'h09, 8'h00, 8'h05, zw, 64'hFFFF_0000_0000_0000, 64'h0040_0000);
    chk("shared rf", 64'h1, {63'h0, xchg.same_rf});
    $display("exit done");
    exec(1'b1, 8'h00, 8'h00, 8'h00, zw, zw, zw);
    repeat (4) @(negedge pclk);
    chk("idle", 64'h6, {61'h0, halted, ext_irq_en, ins_ready});
    @(posedge pclk);
    chan_irq <= 17'h00010;
    @(posedge pclk);
    chan_irq <= 17'h00000;
    for (i = 0; i < 10 && halted !== 1'b0; i++) @(negedge pclk);
    if (i == 10) give_up();
    apb(1'b1, 12'h010, 32'h0000_0010);
    $display("idle done");
    @(posedge pclk);
    slow <= 1'b1;
    exec(1'b1, 8'h0D, 8'h00, 8'h00, zw, zw, zw);
    wait_ready();
    for (i = 0; i < 16; i++) mem_u.mem[i] = zw;
    @(posedge pclk);
    slow <= 1'b0;
    exec(1'b1, 8'h0C, 8'h00, 8'h00, zw, zw, zw);
    wait_ready();
    for (i = 0; i < 16; i++) chk("xr word", 64'hC3A5_0F1E_9B00_0000 | i, mem_u.mem[i]);
    $display("translation registers done");
    give_verdict();
  end
endmodule
